// file: core/ttxlm_core.sv
/*
 * Teletext line mask and status readback of the video encoder register logic.
 * Assumes a serial control port decoder that presents each written byte with its subaddress as a
 * one-cycle strobe, and each read request with its slave address; video timing arrives synchronous
 * to i_sys_clk with line numbers already counted at 50 Hz field rate.
 */
// Contract
// - One mask bit per line 5 to 20 suppresses teletext on that line in both fields.
// - Bit index follows 50 Hz line numbering whatever the video standard.
// - Mask only acts on lines already inside the odd or even request window.
// - Status byte is answered at read slave address 89h; host reads it there.
// - Status bits 7 to 5 hold a fixed version code.
// - Odd caption done clears on caption writes 67h/68h, sets once encoded.
// - Even caption done clears on caption writes 69h/6Ah, sets once encoded.
// - Status bit 2 always reads zero.
// - Status bit 1 high only in first field of 4, 8 or 12 field sequence.
// - Status bit 0 is one during even field, zero during odd field.
// - Even window first line is code plus one, or plus four on M systems.
`timescale 1ns/1ps
module ttxlm_core #(
   parameter logic [2:0] VERSION_CODE = 3'h5  // Value is arbitrary.
) (
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_rst_b,
   input  wire ttxlm_pkg::ttxlm_write_s i_write,
   input  wire logic                    i_read,
   input  wire logic [7:0]              i_read_slave_addr,
   input  wire ttxlm_pkg::ttxlm_timing_s i_timing,
   input  wire ttxlm_pkg::ttxlm_std_e   i_video_std,
   input  wire logic                    i_m_system,
   input  wire ttxlm_pkg::ttxlm_window_s i_window,
   input  wire logic                    i_odd_cc_encoded,
   input  wire logic                    i_even_cc_encoded,
   output logic [7:0]                   o_read_data,
   output logic                         o_read_ack,
   output logic                         o_teletext_line_enable,
   output logic [7:0]                   o_encoder_status
);

   localparam int MASK_W = ttxlm_pkg::MASK_BITS;

   logic [7:0]  teletext_line_mask_low;
   logic [7:0]  teletext_line_mask_high;
   logic [7:0]  next_teletext_line_mask_low;
   logic [7:0]  next_teletext_line_mask_high;

   logic        odd_caption_done;
   logic        even_caption_done;
   logic        next_odd_caption_done;
   logic        next_even_caption_done;

   logic [3:0]  field_count;
   logic [3:0]  next_field_count;
   logic        sequence_first_field;
   logic        next_sequence_first_field;
   logic        field_even;
   logic        next_field_even;

   logic [7:0]  next_read_data;
   logic        next_read_ack;
   logic        next_teletext_line_enable;
   logic [7:0]  encoder_status;

   logic [MASK_W-1:0] line_mask;
   logic [MASK_W-1:0] line_hit;
   logic [3:0]  seq_len;
   logic [8:0]  odd_window_first_line;
   logic [8:0]  odd_window_last_line;
   logic [8:0]  even_window_first_line;
   logic [8:0]  even_window_last_line;
   logic        in_odd_window;
   logic        in_even_window;
   logic        line_masked;

   logic        wr_mask_low;
   logic        wr_mask_high;
   logic        wr_cc_odd;
   logic        wr_cc_even;
   logic        rd_status;

   // Subaddress and slave address decode of the serial control port.
   always_comb begin
      wr_mask_low  = i_write.strobe && i_write.subaddr == ttxlm_pkg::SUB_MASK_LOW;
      wr_mask_high = i_write.strobe && i_write.subaddr == ttxlm_pkg::SUB_MASK_HIGH;
      wr_cc_odd    = i_write.strobe && (i_write.subaddr == ttxlm_pkg::SUB_CC_ODD_0 ||
                                        i_write.subaddr == ttxlm_pkg::SUB_CC_ODD_1);
      wr_cc_even   = i_write.strobe && (i_write.subaddr == ttxlm_pkg::SUB_CC_EVEN_0 ||
                                        i_write.subaddr == ttxlm_pkg::SUB_CC_EVEN_1);
      rd_status    = i_read && i_read_slave_addr == ttxlm_pkg::READ_SLAVE_ADDR;
   end

   // Mask registers written through the serial control port.
   always_comb begin
      next_teletext_line_mask_low  = teletext_line_mask_low;
      next_teletext_line_mask_high = teletext_line_mask_high;
      if (wr_mask_low) begin
         next_teletext_line_mask_low = i_write.data;
      end
      if (wr_mask_high) begin
         next_teletext_line_mask_high = i_write.data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         teletext_line_mask_low  <= ttxlm_pkg::MASK_LOW_RESET;
         teletext_line_mask_high <= ttxlm_pkg::MASK_HIGH_RESET;
      end else begin
         teletext_line_mask_low  <= next_teletext_line_mask_low;
         teletext_line_mask_high <= next_teletext_line_mask_high;
      end
   end

   // Caption completion flags; an encode event in the same cycle as a write wins.
   always_comb begin
      next_odd_caption_done  = odd_caption_done;
      next_even_caption_done = even_caption_done;
      if (wr_cc_odd) begin
         next_odd_caption_done = 1'b0;
      end
      if (i_odd_cc_encoded) begin
         next_odd_caption_done = 1'b1;
      end
      if (wr_cc_even) begin
         next_even_caption_done = 1'b0;
      end
      if (i_even_cc_encoded) begin
         next_even_caption_done = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         odd_caption_done  <= ttxlm_pkg::CC_DONE_RESET;
         even_caption_done <= ttxlm_pkg::CC_DONE_RESET;
      end else begin
         odd_caption_done  <= next_odd_caption_done;
         even_caption_done <= next_even_caption_done;
      end
   end

   // Field sequence and parity tracking.
   always_comb begin
      unique case (i_video_std)
         ttxlm_pkg::STD_NTSC:  seq_len = ttxlm_pkg::SEQ_LEN_NTSC;
         ttxlm_pkg::STD_PAL:   seq_len = ttxlm_pkg::SEQ_LEN_PAL;
         ttxlm_pkg::STD_SECAM: seq_len = ttxlm_pkg::SEQ_LEN_SECAM;
         default:              seq_len = ttxlm_pkg::SEQ_LEN_PAL;
      endcase
   end

   always_comb begin
      next_field_count          = field_count;
      next_sequence_first_field = sequence_first_field;
      next_field_even           = field_even;
      if (i_timing.field_start) begin
         if (field_count >= seq_len - 4'h1) begin
            next_field_count = 4'h0;
         end else begin
            next_field_count = 4'(field_count + 4'h1);
         end
         next_sequence_first_field = (next_field_count == 4'h0);
         next_field_even           = i_timing.field_even;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         field_count          <= 4'h0;
         sequence_first_field <= 1'b0;
         field_even           <= 1'b0;
      end else begin
         field_count          <= next_field_count;
         sequence_first_field <= next_sequence_first_field;
         field_even           <= next_field_even;
      end
   end

   // Status byte assembly.
   always_comb begin
      encoder_status = 8'h00;
      encoder_status[ttxlm_pkg::STAT_VERSION_MSB:ttxlm_pkg::STAT_VERSION_LSB] = VERSION_CODE;
      encoder_status[ttxlm_pkg::STAT_ODD_CC_DONE]  = odd_caption_done;
      encoder_status[ttxlm_pkg::STAT_EVEN_CC_DONE] = even_caption_done;
      encoder_status[ttxlm_pkg::STAT_UNUSED]       = 1'b0;
      encoder_status[ttxlm_pkg::STAT_SEQ_FIRST]    = sequence_first_field;
      encoder_status[ttxlm_pkg::STAT_FIELD_EVEN]   = field_even;
   end

   // Read answer at the transmitter slave address; other addresses get no answer.
   always_comb begin
      next_read_ack  = 1'b0;
      next_read_data = o_read_data;
      if (rd_status) begin
         next_read_ack  = 1'b1;
         next_read_data = encoder_status;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_read_ack       <= 1'b0;
         o_read_data      <= 8'h00;
         o_encoder_status <= 8'h00;
      end else begin
         o_read_ack       <= next_read_ack;
         o_read_data      <= next_read_data;
         o_encoder_status <= encoder_status;
      end
   end

   // Teletext request windows.
   always_comb begin
      if (i_m_system) begin
         odd_window_first_line  = 9'(i_window.odd_first  + ttxlm_pkg::FIRST_OFS_M);
         odd_window_last_line   = 9'(i_window.odd_last   + ttxlm_pkg::LAST_OFS_M);
         even_window_first_line = 9'(i_window.even_first + ttxlm_pkg::FIRST_OFS_M);
         even_window_last_line  = 9'(i_window.even_last  + ttxlm_pkg::LAST_OFS_M);
      end else begin
         odd_window_first_line  = 9'(i_window.odd_first  + ttxlm_pkg::FIRST_OFS_OTHER);
         odd_window_last_line   = 9'(i_window.odd_last   + ttxlm_pkg::LAST_OFS_OTHER);
         even_window_first_line = 9'(i_window.even_first + ttxlm_pkg::FIRST_OFS_OTHER);
         even_window_last_line  = 9'(i_window.even_last  + ttxlm_pkg::LAST_OFS_OTHER);
      end
      in_odd_window  = !i_timing.field_even &&
                       i_timing.line_num >= odd_window_first_line &&
                       i_timing.line_num <= odd_window_last_line;
      in_even_window = i_timing.field_even &&
                       i_timing.line_num >= even_window_first_line &&
                       i_timing.line_num <= even_window_last_line;
   end

   // Per-line mask decode, one mask bit per line from 5 upward.
   assign line_mask = {teletext_line_mask_high, teletext_line_mask_low};

   for (genvar g = 0; g < MASK_W; g++) begin : g_line
      assign line_hit[g] = line_mask[g] &&
                           (i_timing.line_num == ttxlm_pkg::MASK_FIRST_LINE + 9'(g));
   end

   always_comb begin
      line_masked               = |line_hit;
      next_teletext_line_enable = (in_odd_window || in_even_window) && !line_masked;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_teletext_line_enable <= 1'b0;
      end else begin
         o_teletext_line_enable <= next_teletext_line_enable;
      end
   end

endmodule : ttxlm_core

// file: common/ttxlm_pkg.sv
/*
 * Package of the teletext line mask and status readback block: subaddresses, field layout of the
 * status byte, reset values, window offsets and the bundles that travel between ports.
 * Assumes the serial control port decoder outside hands over whole bytes with their subaddress.
 */
package ttxlm_pkg;

   // Slave address at which the status byte is read.
   localparam logic [7:0] READ_SLAVE_ADDR   = 8'h89;

   // Subaddresses seen by this block.
   localparam logic [7:0] SUB_STATUS        = 8'h00;
   localparam logic [7:0] SUB_CC_ODD_0      = 8'h67;
   localparam logic [7:0] SUB_CC_ODD_1      = 8'h68;
   localparam logic [7:0] SUB_CC_EVEN_0     = 8'h69;
   localparam logic [7:0] SUB_CC_EVEN_1     = 8'h6a;
   localparam logic [7:0] SUB_MASK_LOW      = 8'h7e;
   localparam logic [7:0] SUB_MASK_HIGH     = 8'h7f;

   // Status byte fields.
   localparam int STAT_VERSION_MSB          = 7;
   localparam int STAT_VERSION_LSB          = 5;
   localparam int STAT_ODD_CC_DONE          = 4;
   localparam int STAT_EVEN_CC_DONE         = 3;
   localparam int STAT_UNUSED               = 2;
   localparam int STAT_SEQ_FIRST            = 1;
   localparam int STAT_FIELD_EVEN           = 0;

   // Reset values.
   localparam logic [7:0] MASK_LOW_RESET    = 8'h00;
   localparam logic [7:0] MASK_HIGH_RESET   = 8'h00;
   localparam logic       CC_DONE_RESET     = 1'b1;

   // Masked line range, counted at 50 Hz field rate.
   localparam logic [8:0] MASK_FIRST_LINE   = 9'h005;
   localparam logic [8:0] MASK_LAST_LINE    = 9'h014;
   localparam int         MASK_BITS         = 16;

   // Window code offsets.
   localparam logic [8:0] FIRST_OFS_M       = 9'h004;
   localparam logic [8:0] FIRST_OFS_OTHER   = 9'h001;
   localparam logic [8:0] LAST_OFS_M        = 9'h003;
   localparam logic [8:0] LAST_OFS_OTHER    = 9'h000;

   // Colour field sequence lengths.
   localparam logic [3:0] SEQ_LEN_NTSC      = 4'h4;
   localparam logic [3:0] SEQ_LEN_PAL       = 4'h8;
   localparam logic [3:0] SEQ_LEN_SECAM     = 4'hc;

   typedef enum logic [1:0] {
      STD_NTSC  = 2'b00,
      STD_PAL   = 2'b01,
      STD_SECAM = 2'b10
   } ttxlm_std_e;

   // Teletext request window codes, nine bits each.
   typedef struct packed {
      logic [8:0] odd_first;
      logic [8:0] odd_last;
      logic [8:0] even_first;
      logic [8:0] even_last;
   } ttxlm_window_s;

   // Byte written through the serial control port.
   typedef struct packed {
      logic       strobe;
      logic [7:0] subaddr;
      logic [7:0] data;
   } ttxlm_write_s;

   // Video timing seen by the block.
   typedef struct packed {
      logic       field_start;
      logic       field_even;
      logic [8:0] line_num;
   } ttxlm_timing_s;

endpackage : ttxlm_pkg

// file: sim/ttxlm_core_monitor.sv
/* Checker of the status and read ports of ttxlm_core.
   Assumes it is bound to every ttxlm_core instance and shares its clock and reset. */
`timescale 1ns/1ps
module ttxlm_core_monitor #(
   parameter logic [2:0] VERSION_CODE = 3'h5
) (
   input wire logic                     i_sys_clk,
   input wire logic                     i_rst_b,
   input wire ttxlm_pkg::ttxlm_write_s  i_write,
   input wire logic                     i_read,
   input wire logic [7:0]               i_read_slave_addr,
   input wire ttxlm_pkg::ttxlm_timing_s i_timing,
   input wire logic                     i_odd_cc_encoded,
   input wire logic                     i_even_cc_encoded,
   input wire logic [7:0]               o_read_data,
   input wire logic                     o_read_ack,
   input wire logic [7:0]               o_encoder_status
);
   logic rd_ok;
   logic odd_wr;
   logic even_wr;
   assign rd_ok = i_read && (i_read_slave_addr == ttxlm_pkg::READ_SLAVE_ADDR);
   assign odd_wr = i_write.strobe && (i_write.subaddr inside {8'h67, 8'h68});
   assign even_wr = i_write.strobe && (i_write.subaddr inside {8'h69, 8'h6a});
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   a_read_ack_due: assert property (rd_ok |=> o_read_ack)
      else $error("read not acknowledged");
   a_read_refused: assert property (!rd_ok |=> !o_read_ack)
      else $error("acknowledge without a read");
   a_read_fields: assert property (o_read_ack |-> o_read_data[7:5] == VERSION_CODE && !o_read_data[2])
      else $error("read byte has wrong fixed fields");
   a_version_fixed: assert property ($past(i_rst_b) |-> o_encoder_status[7:5] == VERSION_CODE)
      else $error("version field wrong");
   a_unused_zero: assert property (!o_encoder_status[2])
      else $error("unused status bit set");
   a_odd_clear: assert property (odd_wr && !i_odd_cc_encoded |-> ##2 !o_encoder_status[4])
      else $error("odd caption flag not cleared");
   a_odd_set: assert property (i_odd_cc_encoded |-> ##2 o_encoder_status[4])
      else $error("odd caption flag not set");
   a_even_clear: assert property (even_wr && !i_even_cc_encoded |-> ##2 !o_encoder_status[3])
      else $error("even caption flag not cleared");
   a_even_set: assert property (i_even_cc_encoded |-> ##2 o_encoder_status[3])
      else $error("even caption flag not set");
   a_parity_follow: assert property (i_timing.field_start |-> ##2 o_encoder_status[0] == $past(i_timing.field_even, 2))
      else $error("field parity not followed");
endmodule : ttxlm_core_monitor
bind ttxlm_core ttxlm_core_monitor #(.VERSION_CODE(VERSION_CODE)) u_mon (.i_sys_clk, .i_rst_b, .i_write, .i_read,
   .i_read_slave_addr, .i_timing, .i_odd_cc_encoded, .i_even_cc_encoded, .o_read_data, .o_read_ack, .o_encoder_status);

// file: sim/ttxlm_host.sv
/* Serial control host model: issues byte writes and status reads.
   Assumes one testbench process calls its tasks. */
`timescale 1ns/1ps
module ttxlm_host (
   input  wire logic               i_sys_clk,
   output ttxlm_pkg::ttxlm_write_s o_write,
   output logic                    o_read,
   output logic [7:0]              o_addr
);
   initial begin
      o_write = '0;
      o_read = 1'b0;
      o_addr = 8'h00;
   end
   task automatic wr(input logic [7:0] sub, input logic [7:0] dat);
      @(posedge i_sys_clk);
      o_write <= '{1'b1, sub, dat};
      @(posedge i_sys_clk);
      o_write <= '{1'b0, ~sub, ~dat};
   endtask : wr
   task automatic rd(input logic [7:0] adr);
      @(posedge i_sys_clk);
      o_read <= 1'b1;
      o_addr <= adr;
      @(posedge i_sys_clk);
      o_read <= 1'b0;
      o_addr <= ~adr;
   endtask : rd
endmodule : ttxlm_host

// file: sim/test_teletext_line_mask_status_readback.sv
/* Self-checking bench of ttxlm_core with a serial host model.
   Assumes the checker is bound through its own file. */
`timescale 1ns/1ps
module test_teletext_line_mask_status_readback;
   localparam logic [2:0] VER = 3'h5; // Value is arbitrary.
   logic clk = 1'b0;
   logic rst_b, rd, ack, en, m_sys, odd_enc, even_enc, odd_d, even_d, seq, par, ex;
   logic [7:0] radr, rdat, stat, mlo, mhi, exp_b;
   logic [15:0] mk;
   logic [7:0] cc [4] = '{8'h67, 8'h68, 8'h69, 8'h6a};
   logic [7:0] q [$];
   ttxlm_pkg::ttxlm_write_s  wrs;
   ttxlm_pkg::ttxlm_timing_s tim;
   ttxlm_pkg::ttxlm_window_s win;
   ttxlm_pkg::ttxlm_std_e    std;
   int cnt, len, lo, hi, fail_count, n_compared;
   int seed = 27440;
   always #5 clk = ~clk;
   ttxlm_core #(.VERSION_CODE(VER)) dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_write(wrs), .i_read(rd),
      .i_read_slave_addr(radr), .i_timing(tim), .i_video_std(std), .i_m_system(m_sys), .i_window(win),
      .i_odd_cc_encoded(odd_enc), .i_even_cc_encoded(even_enc), .o_read_data(rdat), .o_read_ack(ack),
      .o_teletext_line_enable(en), .o_encoder_status(stat));
   ttxlm_host host (.i_sys_clk(clk), .o_write(wrs), .o_read(rd), .o_addr(radr));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up;
      if (fail_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic reset;
      for (int i = 0; i < 4 && q.size() > 0; i++) @(posedge clk);
      rst_b <= 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      {odd_d, even_d, seq, par, cnt, mlo, mhi} = {4'b1100, 32'd0, 16'h0000};
   endtask : reset
   task automatic read_status(input logic [7:0] a);
      if (a == ttxlm_pkg::READ_SLAVE_ADDR) q.push_back({VER, odd_d, even_d, 1'b0, seq, par});
      host.rd(a);
   endtask : read_status
   task automatic field(input logic ev);
      @(posedge clk);
      tim.field_start <= 1'b1;
      tim.field_even <= ev;
      @(posedge clk);
      tim.field_start <= 1'b0;
      cnt = (cnt + 1) % len;
      {seq, par} = {cnt == 0, ev};
   endtask : field
   task automatic enc(input logic odd);
      @(posedge clk);
      if (odd) odd_enc <= 1'b1;
      else even_enc <= 1'b1;
      @(posedge clk);
      {odd_enc, even_enc} <= 2'b00;
      {odd_d, even_d} = {odd_d | odd, even_d | !odd};
   endtask : enc
   always @(negedge clk) begin
      if (ack === 1'b1) begin
         exp_b = (q.size() > 0) ? q.pop_front() : 8'hxx;
         chk(rdat, exp_b);
         chk(stat, exp_b);
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
   initial begin
      {rst_b, m_sys, odd_enc, even_enc, fail_count, n_compared} = '0;
      {tim, std} = '0;
      win = '{9'h003, 9'h012, 9'h006, 9'h016};
      for (int s = 0; s < 3; s++) begin
         std <= ttxlm_pkg::ttxlm_std_e'(s);
         len = 4 * (s + 1);
         reset();
         read_status(8'h89);
         for (int f = 0; f <= len; f++) begin
            field(1'($random(seed)));
            read_status(8'h89);
         end
      end
      for (int i = 0; i < 4; i++) begin
         host.wr(cc[i], 8'($random(seed)));
         if (i < 2) odd_d = 1'b0;
         else even_d = 1'b0;
         read_status(8'h89);
         read_status(8'h88);
         enc(i < 2);
         read_status(8'h89);
      end
      for (int k = 0; k < 5; k++) begin
         if (k == 1) begin
            {mhi, mlo} = 16'($random(seed));
            host.wr(8'h7e, mlo);
            host.wr(8'h7f, mhi);
         end
         for (int n = 0; n < 26; n++) begin
            @(posedge clk);
            {m_sys, tim.field_even, tim.line_num} <= {k > 2, k % 2 == 1, 9'(n)};
            std <= (k > 2) ? ttxlm_pkg::STD_NTSC : ttxlm_pkg::STD_PAL;
            lo = ((k % 2) ? win.even_first : win.odd_first) + ((k > 2) ? 4 : 1);
            hi = ((k % 2) ? win.even_last : win.odd_last) + ((k > 2) ? 3 : 0);
            mk = {mhi, mlo};
            ex = n >= lo && n <= hi && !(n >= 5 && n <= 20 && mk[n - 5]);
            @(posedge clk);
            #1;
            chk({7'h00, en}, {7'h00, ex});
         end
      end
      for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk);
      if (q.size() > 0) chk(8'h00, 8'hff);
      wrap_up();
   end
endmodule : test_teletext_line_mask_status_readback
